// ### bench/dpc_host_model.sv
`timescale 1ns/1ps
module dpc_host_model (
  // Bus
  input wire logic i_clk,
  input wire dpc_pkg::dpc_rsp_t i_rsp,
  output dpc_pkg::dpc_req_t o_req
);
  import dpc_pkg::*;
  initial o_req = '0;
  // Reserved bit three is always sent as one
  task automatic write_reg(input logic [23:0] a, input logic [7:0] d);
    @(negedge i_clk);
    o_req = '{CMD_WRITE_ANY, a, d | 8'h08};
    @(negedge i_clk);
    o_req = '0;
  endtask : write_reg
  task automatic read_reg(input dpc_cmd_t c, input logic [23:0] a, output dpc_rsp_t r);
    @(negedge i_clk);
    o_req = '{c, a, 8'h00};
    @(negedge i_clk);
    r = i_rsp;
    o_req = '0;
  endtask : read_reg
endmodule : dpc_host_model

// ### bench/test_dpc_config_reg.sv
`timescale 1ns/1ps
module test_dpc_config_reg;
  import dpc_pkg::*;
  logic clk = 0;
  logic rst = 1;
  logic hw = 0;
  logic sw = 0;
  logic cs_n = 1;
  logic wake = 0;
  dpc_req_t req;
  dpc_rsp_t rsp;
  dpc_rsp_t r;
  logic [2:0] sel;
  logic [6:0] ohm;
  logic pdr;
  dpc_pstate_t ps;
  logic [7:0] pers;
  int miscompares = 0;
  int check_count = 0;
  int ohm_tab [8] = '{45, 120, 90, 60, 45, 30, 20, 20};
  dpc_config_reg dpc_config_reg_inst (.I_CLK_SYS(clk), .I_RST(rst), .i_hw_reset(hw),
    .i_sw_reset(sw), .i_cs_n(cs_n), .i_wake_pulse(wake), .i_req(req), .o_rsp(rsp),
    .o_drive_impedance_sel(sel), .o_impedance_ohm(ohm), .o_powerdown_on_reset_en(pdr),
    .o_pstate(ps), .o_persist(pers));
  dpc_host_model dpc_host_model_inst (.i_clk(clk), .i_rsp(rsp), .o_req(req));
  initial forever #25 clk = ~clk;
  // ****************************************************************
  // Checking helpers
  // ****************************************************************
  task automatic finish_test;
    $display("checks=%0d miscompares=%0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : finish_test
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic pulse(input int w);
    @(negedge clk);
    {wake, sw, hw} = 3'(1 << w);
    @(negedge clk);
    {wake, sw, hw} = 3'h0;
  endtask : pulse
  task automatic wait_ps(input dpc_pstate_t e);
    for (int k = 0; k < 4 && ps !== e; k++) @(negedge clk);
    chk(8'(ps), 8'(e));
  endtask : wait_ps
  // ****************************************************************
  // Tests
  // ****************************************************************
  initial begin
    repeat (20) @(negedge clk);
    rst = 0;
    repeat (2) @(negedge clk);
    chk(8'(ps), 8'(PS_STANDBY));
    chk(pers, 8'h08);
    dpc_host_model_inst.read_reg(CMD_READ_ANY, ADDR_PERSIST, r);
    chk(r.rdata, 8'h08);
    chk({6'h0, r.valid, r.hit}, 8'h03);
    dpc_host_model_inst.write_reg(ADDR_WORK, 8'hf7);
    dpc_host_model_inst.read_reg(CMD_READ_DRIVE, ADDR_WORK, r);
    chk(r.rdata, 8'hec);
    chk(pers, 8'h08);
    chk({5'h0, sel}, 8'h07);
    dpc_host_model_inst.read_reg(CMD_READ_ANY, 24'h000006, r);
    chk(r.rdata | {7'h0, r.hit}, 8'h00);
    chk({7'h0, r.valid}, 8'h01);
    dpc_host_model_inst.write_reg(ADDR_PERSIST, 8'h2c);
    chk(pers, 8'h2c);
    dpc_host_model_inst.write_reg(24'h070006, 8'hff);
    chk(pers, 8'h2c);
    dpc_host_model_inst.read_reg(CMD_READ_ANY, ADDR_WORK, r);
    chk(r.rdata, 8'hec);
    for (int k = 0; k < 8; k++) begin
      dpc_host_model_inst.write_reg(ADDR_WORK, 8'(k << 5));
      chk({1'b0, ohm}, 8'(ohm_tab[k]));
    end
    dpc_host_model_inst.write_reg(ADDR_WORK, 8'h04);
    chk({7'h0, pdr}, 8'h01);
    pulse(0);
    wait_ps(PS_DEEP_SLEEP);
    pulse(2);
    wait_ps(PS_STANDBY);
    pulse(0);
    wait_ps(PS_DEEP_SLEEP);
    pulse(1);
    wait_ps(PS_STANDBY);
    pulse(0);
    wait_ps(PS_DEEP_SLEEP);
    pulse(0);
    wait_ps(PS_STANDBY);
    cs_n = 0;
    pulse(0);
    repeat (3) @(negedge clk);
    chk(8'(ps), 8'(PS_STANDBY));
    cs_n = 1;
    finish_test;
  end
  initial begin
    #100000;
    miscompares++;
    finish_test;
  end
endmodule : test_dpc_config_reg

// ### pkg/dpc_pkg.sv
package dpc_pkg;

  // ****************************************************************
  // Register addresses
  // ****************************************************************
  localparam logic [23:0] ADDR_PERSIST = 24'h000005;
  localparam logic [23:0] ADDR_WORK = 24'h070005;

  // ****************************************************************
  // Field layout and factory value
  // ****************************************************************
  localparam int IMP_MSB = 7;
  localparam int IMP_LSB = 5;
  localparam int RSV4_POS = 4;
  localparam int RSV3_POS = 3;
  localparam int PDR_POS = 2;
  localparam logic [7:0] FACTORY_VAL = 8'h08;
  localparam logic [7:0] WRITE_MASK = 8'he4;
  localparam logic [7:0] FORCE_ONE = 8'h08;

  // ****************************************************************
  // Power states and request carrier
  // ****************************************************************
  typedef enum logic [1:0] {
    PS_RESET,
    PS_STANDBY,
    PS_DEEP_SLEEP
  } dpc_pstate_t;

  typedef enum logic [1:0] {
    CMD_NONE,
    CMD_WRITE_ANY,
    CMD_READ_ANY,
    CMD_READ_DRIVE
  } dpc_cmd_t;

  typedef struct packed {
    dpc_cmd_t cmd;
    logic [23:0] addr;
    logic [7:0] wdata;
  } dpc_req_t;

  typedef struct packed {
    logic valid;
    logic hit;
    logic [7:0] rdata;
  } dpc_rsp_t;

endpackage : dpc_pkg

// ### rtl/dpc_config_reg.sv
`timescale 1ns/1ps
// Operation
// R1: Written only by write-any command; read by read-drive or read-any command.
// R2: Write-any at persistent address updates the persistent copy.
// R3: Write-any at working address updates only the working copy.
// R4: Read-any at either address returns the register contents; the code returns the working copy at both addresses.
// R5: Factory value is zero except reserved bit three, which is one.
// R6: Bits seven to five are the read/write drive impedance field.
// R7: Host must always write one into bit three.
// R8: Bits four, one and zero are reserved and read zero.
// R9: Enable set: deep sleep after power-on or hardware reset with select high.
// R10: Enable clear: standby after power-up or hardware reset with select high.
// R11: Software reset always leads to standby.
// R12: Deep sleep is left on a select pulse or a hardware reset.
// R13: Drive code maps to typical impedance 45,120,90,60,45,30,20,20 ohm.
// R14: Power-up loads working copy from persistent; working writes act at once.
// R15: Power-down decision uses the bit value held when reset completes.
module dpc_config_reg (
  // Clock and reset
  input wire logic I_CLK_SYS,
  input wire logic I_RST,
  // Reset events, select and wake pulse from the device core
  input wire logic i_hw_reset,
  input wire logic i_sw_reset,
  input wire logic i_cs_n,
  input wire logic i_wake_pulse,
  // Register access
  input wire dpc_pkg::dpc_req_t i_req,
  output dpc_pkg::dpc_rsp_t o_rsp,
  // Configuration outputs
  output logic [2:0] o_drive_impedance_sel,
  output logic [6:0] o_impedance_ohm,
  output logic o_powerdown_on_reset_en,
  output dpc_pkg::dpc_pstate_t o_pstate,
  output logic [7:0] o_persist
);
  import dpc_pkg::*;

  // ****************************************************************
  // Access decode
  // ****************************************************************
  logic [7:0] persist_r;
  logic [7:0] work_r;
  logic [7:0] work_nxt;
  logic [7:0] persist_nxt;
  dpc_pstate_t pstate_r;
  dpc_pstate_t pstate_nxt;
  dpc_rsp_t rsp_r;
  logic hw_d_r;
  logic sw_d_r;
  logic [6:0] ohm;

  wire hit_p = (i_req.addr == ADDR_PERSIST);
  wire hit_w = (i_req.addr == ADDR_WORK);
  wire wr_p = (i_req.cmd == CMD_WRITE_ANY) && hit_p; // see R1 see R2
  wire wr_w = (i_req.cmd == CMD_WRITE_ANY) && hit_w; // see R3
  wire rd_any = (i_req.cmd == CMD_READ_ANY) && (hit_p || hit_w); // see R4
  wire rd_drv = (i_req.cmd == CMD_READ_DRIVE); // see R1
  // Writable bits kept, reserved zeros enforced, bit three held high
  wire [7:0] wval = (i_req.wdata & WRITE_MASK) | FORCE_ONE; // see R6 see R7 see R8
  wire [7:0] rsv_mask = ~(WRITE_MASK | FORCE_ONE); // see R8
  wire hw_done = hw_d_r && !i_hw_reset;
  wire sw_done = sw_d_r && !i_sw_reset;

  // ****************************************************************
  // Register copies
  // ****************************************************************
  assign persist_nxt = wr_p ? wval : persist_r; // see R2
  assign work_nxt = wr_w ? wval : work_r; // see R3 see R14

  always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
    if (I_RST) begin
      persist_r <= FACTORY_VAL; // see R5
    end else begin
      persist_r <= persist_nxt;
    end
  end

  always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
    if (I_RST) begin
      work_r <= FACTORY_VAL;
    end else if (pstate_r == PS_RESET) begin
      work_r <= persist_r; // see R14
    end else begin
      work_r <= work_nxt;
    end
  end

  // ****************************************************************
  // Power state after reset
  // ****************************************************************
  always_comb begin
    pstate_nxt = pstate_r;
    case (pstate_r)
      PS_RESET: begin
        if (i_cs_n) begin
          pstate_nxt = persist_r[PDR_POS] ? PS_DEEP_SLEEP : PS_STANDBY; // see R9 see R10 see R15
        end
      end
      PS_STANDBY: begin
        if (hw_done && i_cs_n) begin
          pstate_nxt = work_r[PDR_POS] ? PS_DEEP_SLEEP : PS_STANDBY; // see R9 see R15
        end
      end
      PS_DEEP_SLEEP: begin
        if (i_wake_pulse || hw_done) begin
          pstate_nxt = PS_STANDBY; // see R12
        end
      end
      default: pstate_nxt = PS_RESET;
    endcase
    if (sw_done) begin
      pstate_nxt = PS_STANDBY; // see R11
    end
  end

  always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
    if (I_RST) begin
      pstate_r <= PS_RESET;
      hw_d_r <= 1'b0;
      sw_d_r <= 1'b0;
    end else begin
      pstate_r <= pstate_nxt;
      hw_d_r <= i_hw_reset;
      sw_d_r <= i_sw_reset;
    end
  end

  // ****************************************************************
  // Read answer
  // ****************************************************************
  always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
    if (I_RST) begin
      rsp_r <= '0;
    end else begin
      rsp_r.valid <= (i_req.cmd == CMD_READ_ANY) || rd_drv;
      rsp_r.hit <= rd_any || rd_drv;
      rsp_r.rdata <= (rd_any || rd_drv) ? work_r : 8'h00; // see R4
    end
  end

  // ****************************************************************
  // Impedance lookup
  // ****************************************************************
  always_comb begin
    case (work_r[IMP_MSB:IMP_LSB]) // see R13
      3'h0: ohm = 7'h2d;
      3'h1: ohm = 7'h78;
      3'h2: ohm = 7'h5a;
      3'h3: ohm = 7'h3c;
      3'h4: ohm = 7'h2d;
      3'h5: ohm = 7'h1e;
      default: ohm = 7'h14;
    endcase
  end

  assign o_rsp = rsp_r;
  assign o_drive_impedance_sel = work_r[IMP_MSB:IMP_LSB];
  assign o_impedance_ohm = ohm;
  assign o_powerdown_on_reset_en = work_r[PDR_POS];
  assign o_pstate = pstate_r;
  assign o_persist = persist_r;

  // ****************************************************************
  // Register checks
  // ****************************************************************
  AST_FACTORY: assert property (@(posedge I_CLK_SYS) $fell(I_RST) |-> persist_r == FACTORY_VAL) // see R5
    else $error("factory value wrong");
  AST_PWRITE: assert property (@(posedge I_CLK_SYS) disable iff (I_RST) // see R2
    wr_p |=> persist_r == $past(wval)) else $error("persistent write lost");
  AST_WWRITE: assert property (@(posedge I_CLK_SYS) disable iff (I_RST) // see R3
    wr_w && pstate_r != PS_RESET |=> work_r == $past(wval) && $stable(persist_r))
    else $error("working write wrong");
  AST_RSV: assert property (@(posedge I_CLK_SYS) disable iff (I_RST) // see R8
    (work_r & rsv_mask) == 8'h00 && (persist_r & rsv_mask) == 8'h00)
    else $error("reserved bits wrong");
  AST_BIT3: assert property (@(posedge I_CLK_SYS) disable iff (I_RST) // see R7 see R5
    work_r[RSV3_POS] && persist_r[RSV3_POS]) else $error("bit three cleared");
  AST_READ: assert property (@(posedge I_CLK_SYS) disable iff (I_RST) // see R4
    rd_any |=> o_rsp.valid && o_rsp.rdata == $past(work_r)) else $error("read wrong");
  AST_MISS: assert property (@(posedge I_CLK_SYS) disable iff (I_RST) // see R4
    i_req.cmd == CMD_READ_ANY && !hit_p && !hit_w |=> o_rsp.valid && !o_rsp.hit
    && o_rsp.rdata == 8'h00) else $error("unmapped read not refused");
  AST_RDRV: assert property (@(posedge I_CLK_SYS) disable iff (I_RST) // see R1
    rd_drv |=> o_rsp.valid && o_rsp.hit && o_rsp.rdata == $past(work_r))
    else $error("drive config read wrong");
  AST_NOWR: assert property (@(posedge I_CLK_SYS) disable iff (I_RST) // see R1
    i_req.cmd != CMD_WRITE_ANY && pstate_r != PS_RESET |=> $stable(work_r) && $stable(persist_r))
    else $error("register changed without write");
  AST_IMPED: assert property (@(posedge I_CLK_SYS) disable iff (I_RST) // see R13
    work_r[IMP_MSB:IMP_LSB] == 3'h1 |-> o_impedance_ohm == 7'h78)
    else $error("impedance map wrong");
  AST_IMPALIAS: assert property (@(posedge I_CLK_SYS) disable iff (I_RST) // see R13
    work_r[IMP_MSB:IMP_LSB] == 3'h4 |-> o_impedance_ohm == 7'h2d)
    else $error("impedance alias wrong");

  // ****************************************************************
  // Power state checks
  // ****************************************************************
  AST_POR: assert property (@(posedge I_CLK_SYS) disable iff (I_RST) // see R9
    pstate_r == PS_RESET && i_cs_n && persist_r[PDR_POS] && !sw_done |=> pstate_r == PS_DEEP_SLEEP)
    else $error("no deep sleep after reset");
  AST_SWR: assert property (@(posedge I_CLK_SYS) disable iff (I_RST) // see R11
    sw_done |=> pstate_r == PS_STANDBY) else $error("soft reset not standby");
  AST_WAKE: assert property (@(posedge I_CLK_SYS) disable iff (I_RST) // see R12
    pstate_r == PS_DEEP_SLEEP && i_wake_pulse |=> pstate_r == PS_STANDBY)
    else $error("no wake");
  AST_LOAD: assert property (@(posedge I_CLK_SYS) disable iff (I_RST) // see R14
    pstate_r == PS_RESET |=> work_r == $past(persist_r)) else $error("no load");
  AST_HWDEEP: assert property (@(posedge I_CLK_SYS) disable iff (I_RST) // see R9 see R15
    pstate_r == PS_STANDBY && hw_done && i_cs_n && work_r[PDR_POS] && !sw_done
    |=> pstate_r == PS_DEEP_SLEEP) else $error("no deep sleep after hardware reset");
  AST_HWSTBY: assert property (@(posedge I_CLK_SYS) disable iff (I_RST) // see R10
    pstate_r == PS_STANDBY && hw_done && !work_r[PDR_POS] |=> pstate_r == PS_STANDBY)
    else $error("left standby after hardware reset");
  AST_CSLOW: assert property (@(posedge I_CLK_SYS) disable iff (I_RST) // see R9
    pstate_r == PS_STANDBY && hw_done && !i_cs_n |=> pstate_r == PS_STANDBY)
    else $error("deep sleep entered with select low");
  AST_HWWAKE: assert property (@(posedge I_CLK_SYS) disable iff (I_RST) // see R12
    pstate_r == PS_DEEP_SLEEP && hw_done |=> pstate_r == PS_STANDBY)
    else $error("hardware reset did not wake");

endmodule : dpc_config_reg
